/* File: core/fsi_injector.sv */
// Symbol injection logic of the transmit path with its control bus registers
// Contract
// [RULE1] Reload counter at zero and on threshold write
// [RULE2] Eight-bit down-counter, one step per 80 ns
// [RULE3] Current count readable by software
// [RULE4] Counter runs only in one-shot or periodic
// [RULE5] Counter zero replaces one data pair
// [RULE6] One-shot threshold zero replaces JK pair
// [RULE7] Periodic threshold zero replaces every pair
// [RULE8] Counter is zero during reset
// [RULE9] Injected code groups bypass the encoder unchanged
// [RULE10] Symbols leave most significant bit first
// [RULE11] One-shot injects n pairs after JK
// [RULE12] Periodic injects at every n-th pair; the code reloads n after zero, so it injects at every (n+1)-th pair
// [RULE13] Continuous replaces every pair, counter unused
// [RULE14] Symbol upper bits read zero, no effect
// [RULE15] One-shot completion clears low mode bit
// [RULE16] Injection overrides all upstream symbol sources
// [RULE17] Mode codes 00 none, 01, 10, 11
// [RULE18] Counter steps on pair boundaries only
`timescale 1ns/10ps
module fsi_injector (
    // Clock, reset, enable
    input  wire logic                 sys_clk_in,
    input  wire logic                 nrst_in,
    input  wire logic                 ce_in,
    // Control bus
    input  wire fsi_pkg::fsi_cb_req_t cb_req_in,
    output logic [7:0]                cb_rdata_out,
    // Upstream symbol pairs
    input  wire fsi_pkg::fsi_pair_t   pair_in,
    input  wire logic                 pair_jk_in,
    output logic                      pair_take_out,
    // Medium side
    output fsi_pkg::fsi_pair_t        tx_pair_out,
    output logic                      tx_injected_out,
    output logic                      tx_bit_out
);

    // Reset release
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Bit and pair timing: 10 bit slots spread over 16 cycles
    logic [3:0] phase_q;
    logic [3:0] phase_d;
    logic [3:0] cyc_q;
    logic [3:0] cyc_d;
    logic [4:0] phase_sum;
    logic       bit_wrap;
    logic       tick;
    logic       shift;

    always_comb begin
        phase_sum = {1'b0, phase_q} + fsi_pkg::PHASE_STEP;
        bit_wrap  = (phase_sum >= fsi_pkg::PHASE_WRAP);
        phase_d   = bit_wrap ? 4'(phase_sum - fsi_pkg::PHASE_WRAP) : phase_sum[3:0];
        tick      = (cyc_q == fsi_pkg::CYC_LAST); // see [RULE2]
        cyc_d     = tick ? 4'h0 : 4'(cyc_q + 4'h1);
        shift     = bit_wrap && !tick;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            phase_q <= 4'h0;
            cyc_q   <= 4'h0;
        end else if (ce_in) begin
            phase_q <= phase_d;
            cyc_q   <= cyc_d;
        end
    end

    assign pair_take_out = tick && ce_in;

    // Registers
    logic [7:0] tsr_q;
    logic [7:0] tsr_d;
    logic [7:0] thr_q;
    logic [7:0] thr_d;
    logic [4:0] syma_q;
    logic [4:0] syma_d;
    logic [4:0] symb_q;
    logic [4:0] symb_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       wr_tsr;
    logic       wr_thr;
    logic       wr_syma;
    logic       wr_symb;

    // Injection state
    logic [7:0]          cnt_q;
    logic [7:0]          cnt_d;
    fsi_pkg::fsi_os_t    os_q;
    fsi_pkg::fsi_os_t    os_d;
    fsi_pkg::fsi_mode_t  mode;
    fsi_pkg::fsi_pair_t  inj_pair;
    fsi_pkg::fsi_pair_t  tx_sel;
    fsi_pkg::fsi_pair_t  tx_pair_q;
    fsi_pkg::fsi_pair_t  tx_pair_d;
    logic                inj_q;
    logic                inj_d;
    logic                inject;
    logic                clr_lo;

    assign mode     = fsi_pkg::fsi_mode_t'(tsr_q[fsi_pkg::MODE_HI_BIT:fsi_pkg::MODE_LO_BIT]); // see [RULE17]
    assign inj_pair = fsi_pkg::fsi_pair_t'({syma_q, symb_q});
    assign wr_tsr   = cb_req_in.wr && (cb_req_in.addr == fsi_pkg::TSR_OFS);
    assign wr_thr   = cb_req_in.wr && (cb_req_in.addr == fsi_pkg::THR_OFS);
    assign wr_syma  = cb_req_in.wr && (cb_req_in.addr == fsi_pkg::SYMA_OFS);
    assign wr_symb  = cb_req_in.wr && (cb_req_in.addr == fsi_pkg::SYMB_OFS);

    // Counter and one-shot sequencing, evaluated once per pair
    always_comb begin
        cnt_d  = cnt_q;
        os_d   = os_q;
        inject = 1'b0;
        clr_lo = 1'b0;
        if (tick) begin // see [RULE18]
            unique case (mode)
                fsi_pkg::FSI_MODE_NONE: begin
                    os_d = fsi_pkg::FSI_OS_IDLE; // see [RULE4]
                end
                fsi_pkg::FSI_MODE_ONESHOT: begin
                    if (pair_jk_in) begin
                        // A JK restarts the count even mid-run
                        if (thr_q == 8'h00) begin
                            inject = 1'b1; // see [RULE6]
                            clr_lo = 1'b1;
                            cnt_d  = thr_q;
                            os_d   = fsi_pkg::FSI_OS_IDLE;
                        end else begin
                            cnt_d = 8'(thr_q - 8'h01); // see [RULE11]
                            os_d  = fsi_pkg::FSI_OS_ARMED;
                        end
                    end else if (os_q == fsi_pkg::FSI_OS_ARMED) begin
                        if (cnt_q == 8'h00) begin
                            inject = 1'b1; // see [RULE5]
                            clr_lo = 1'b1; // see [RULE15]
                            cnt_d  = thr_q; // see [RULE1]
                            os_d   = fsi_pkg::FSI_OS_IDLE;
                        end else begin
                            cnt_d = 8'(cnt_q - 8'h01); // see [RULE2]
                        end
                    end
                end
                fsi_pkg::FSI_MODE_PERIODIC: begin
                    os_d = fsi_pkg::FSI_OS_IDLE;
                    if (cnt_q == 8'h00) begin
                        inject = 1'b1; // see [RULE12] [RULE7]
                        cnt_d  = thr_q; // see [RULE1]
                    end else begin
                        cnt_d = 8'(cnt_q - 8'h01); // see [RULE2]
                    end
                end
                fsi_pkg::FSI_MODE_CONT: begin
                    inject = 1'b1; // see [RULE13]
                    os_d   = fsi_pkg::FSI_OS_IDLE;
                end
            endcase
        end
        if (wr_thr) begin
            cnt_d = cb_req_in.wdata; // see [RULE1]
        end
    end

    // Output selection; injection outranks every upstream source
    always_comb begin
        tx_sel    = inject ? inj_pair : pair_in; // see [RULE16] [RULE9]
        tx_pair_d = tick ? tx_sel : tx_pair_q;
        inj_d     = tick ? inject : inj_q;
    end

    // Register file; a software write beats the hardware clear
    always_comb begin
        tsr_d  = tsr_q;
        thr_d  = thr_q;
        syma_d = syma_q;
        symb_d = symb_q;
        if (clr_lo) begin
            tsr_d[fsi_pkg::MODE_LO_BIT] = 1'b0; // see [RULE15]
        end
        if (wr_tsr) begin
            tsr_d = cb_req_in.wdata;
        end
        if (wr_thr) begin
            thr_d = cb_req_in.wdata;
        end
        if (wr_syma) begin
            syma_d = cb_req_in.wdata[4:0]; // see [RULE14]
        end
        if (wr_symb) begin
            symb_d = cb_req_in.wdata[4:0]; // see [RULE14]
        end
        rdata_d = rdata_q;
        if (cb_req_in.rd) begin
            unique case (cb_req_in.addr)
                fsi_pkg::TSR_OFS:  rdata_d = tsr_q;
                fsi_pkg::THR_OFS:  rdata_d = thr_q;
                fsi_pkg::SYMA_OFS: rdata_d = {fsi_pkg::SYM_PAD, syma_q}; // see [RULE14]
                fsi_pkg::SYMB_OFS: rdata_d = {fsi_pkg::SYM_PAD, symb_q};
                fsi_pkg::CNT_OFS:  rdata_d = cnt_q; // see [RULE3]
                default:           rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tsr_q     <= fsi_pkg::TSR_RESET;
            thr_q     <= fsi_pkg::THR_RESET;
            syma_q    <= fsi_pkg::SYM_RESET;
            symb_q    <= fsi_pkg::SYM_RESET;
            rdata_q   <= 8'h00;
            cnt_q     <= fsi_pkg::CNT_RESET; // see [RULE8]
            os_q      <= fsi_pkg::FSI_OS_IDLE;
            tx_pair_q <= '0;
            inj_q     <= 1'b0;
        end else if (ce_in) begin
            tsr_q     <= tsr_d;
            thr_q     <= thr_d;
            syma_q    <= syma_d;
            symb_q    <= symb_d;
            rdata_q   <= rdata_d;
            cnt_q     <= cnt_d;
            os_q      <= os_d;
            tx_pair_q <= tx_pair_d;
            inj_q     <= inj_d;
        end
    end

    assign cb_rdata_out    = rdata_q;
    assign tx_pair_out     = tx_pair_q;
    assign tx_injected_out = inj_q;

    // Serial path loads the same pair that is registered above
    fsi_shifter u_shifter (
        .clk_in   (sys_clk_in),
        .rst_n_in (rst_n_q),
        .ce_in    (ce_in),
        .load_in  (tick),
        .shift_in (shift),
        .pair_in  (tx_sel),
        .bit_out  (tx_bit_out)
    );

    // Checks
    chk_thr_write_load: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // see [RULE1]
        ce_in && wr_thr |=> cnt_q == $past(cb_req_in.wdata))
        else $error("threshold write did not load counter");

    chk_zero_reload: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // see [RULE1]
        ce_in && tick && mode == fsi_pkg::FSI_MODE_PERIODIC && cnt_q == 8'h00 && !wr_thr
        |=> cnt_q == $past(thr_q))
        else $error("counter not reloaded at zero");

    chk_pair_decrement: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // see [RULE2]
        ce_in && tick && mode == fsi_pkg::FSI_MODE_PERIODIC && cnt_q != 8'h00 && !wr_thr
        |=> cnt_q == 8'($past(cnt_q) - 8'h01))
        else $error("counter did not step down by one");

    chk_hold_between: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // see [RULE18]
        ce_in && !tick && !wr_thr |=> $stable(cnt_q))
        else $error("counter moved off a pair boundary");

    // Separate count of enabled cycles, so a slip of the pair timer shows
    logic [3:0] chk_gap_q;
    logic [3:0] chk_gap_d;

    always_comb begin
        chk_gap_d = tick ? 4'h0 : 4'(chk_gap_q + 4'h1);
    end
    always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            chk_gap_q <= 4'h0;
        end else if (ce_in) begin
            chk_gap_q <= chk_gap_d;
        end
    end

    chk_tick_period: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // see [RULE2]
        ce_in |-> tick == (chk_gap_q == fsi_pkg::CYC_LAST))
        else $error("pair period is not sixteen cycles");

    chk_idle_modes: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // see [RULE4]
        ce_in && !wr_thr && (mode == fsi_pkg::FSI_MODE_NONE || mode == fsi_pkg::FSI_MODE_CONT)
        |=> $stable(cnt_q))
        else $error("counter ran outside counting modes");

    chk_count_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // see [RULE3]
        ce_in && cb_req_in.rd && cb_req_in.addr == fsi_pkg::CNT_OFS |=> cb_rdata_out == $past(cnt_q))
        else $error("current count read wrong");

    chk_cont_replace: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // see [RULE13]
        ce_in && tick && mode == fsi_pkg::FSI_MODE_CONT
        |=> tx_injected_out && tx_pair_out == {$past(syma_q), $past(symb_q)})
        else $error("continuous mode passed data");

    chk_periodic_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // see [RULE5]
        ce_in && tick && mode == fsi_pkg::FSI_MODE_PERIODIC && cnt_q == 8'h00 |=> tx_injected_out)
        else $error("no injection at count zero");

    chk_jk_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // see [RULE6]
        ce_in && tick && mode == fsi_pkg::FSI_MODE_ONESHOT && pair_jk_in && thr_q == 8'h00
        |=> tx_injected_out)
        else $error("JK pair not replaced");

    chk_oneshot_ack: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // see [RULE15]
        ce_in && clr_lo && !wr_tsr |=> !tsr_q[fsi_pkg::MODE_LO_BIT])
        else $error("one-shot did not clear low mode bit");

    chk_sym_upper: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // see [RULE14]
        ce_in && cb_req_in.rd && (cb_req_in.addr == fsi_pkg::SYMA_OFS || cb_req_in.addr == fsi_pkg::SYMB_OFS)
        |=> cb_rdata_out[7:5] == 3'h0)
        else $error("symbol upper bits not zero");

    chk_msb_first: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // see [RULE10]
        ce_in && tick |=> tx_bit_out == tx_pair_out.first[4])
        else $error("serial output not MSB first");

    chk_reset_count: assert property (@(posedge sys_clk_in) // see [RULE8]
        !rst_n_q |-> cnt_q == 8'h00)
        else $error("counter not zero in reset");

endmodule

/* File: core/fsi_pkg.sv */
// Constants, types and register map of the symbol injection block
package fsi_pkg;

    // Control bus
    localparam int unsigned CB_ADDR_W      = 5;
    localparam int unsigned CB_DATA_W      = 8;
    localparam logic [4:0]  TSR_OFS        = 5'h04;
    localparam logic [4:0]  THR_OFS        = 5'h05;
    localparam logic [4:0]  SYMA_OFS       = 5'h06;
    localparam logic [4:0]  SYMB_OFS       = 5'h07;
    localparam logic [4:0]  CNT_OFS        = 5'h0f;

    // Transmit state register fields
    localparam int unsigned MODE_LO_BIT    = 3;
    localparam int unsigned MODE_HI_BIT    = 4;
    localparam logic [7:0]  TSR_RESET      = 8'h80;

    // Threshold and symbols
    localparam int unsigned CNT_W          = 8;
    localparam int unsigned SYM_W          = 5;
    localparam logic [7:0]  THR_RESET      = 8'h00;
    localparam logic [7:0]  CNT_RESET      = 8'h00;
    localparam logic [4:0]  SYM_RESET      = 5'h00;
    localparam logic [2:0]  SYM_PAD        = 3'h0;

    // Timing
    localparam int unsigned CLK_PERIOD_NS  = 5;
    localparam int unsigned PAIR_TIME_NS   = 80;
    localparam int unsigned PAIR_CYCLES    = (PAIR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BITS_PER_PAIR  = 2 * SYM_W;
    localparam int unsigned PHASE_W        = 5;
    localparam logic [4:0]  PHASE_STEP     = 5'(BITS_PER_PAIR);
    localparam logic [4:0]  PHASE_WRAP     = 5'(PAIR_CYCLES);
    localparam logic [3:0]  CYC_LAST       = 4'(PAIR_CYCLES - 1);

    typedef enum logic [1:0] {
        FSI_MODE_NONE     = 2'b00,
        FSI_MODE_ONESHOT  = 2'b01,
        FSI_MODE_PERIODIC = 2'b10,
        FSI_MODE_CONT     = 2'b11
    } fsi_mode_t;

    typedef enum logic [0:0] {
        FSI_OS_IDLE  = 1'b0,
        FSI_OS_ARMED = 1'b1
    } fsi_os_t;

    typedef struct packed {
        logic [4:0] first;
        logic [4:0] second;
    } fsi_pair_t;

    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } fsi_cb_req_t;

endpackage

/* File: core/fsi_shifter.sv */
// Serialiser for one 10-bit code pair, first bit out is the pair MSB
`timescale 1ns/10ps
module fsi_shifter (
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              ce_in,
    // Control
    input  wire logic              load_in,
    input  wire logic              shift_in,
    input  wire fsi_pkg::fsi_pair_t pair_in,
    // Serial out
    output logic                   bit_out
);

    logic [9:0] sr_q;
    logic [9:0] sr_d;

    always_comb begin
        sr_d = sr_q;
        if (load_in) begin
            sr_d = pair_in; // see [RULE10]
        end else if (shift_in) begin
            sr_d = {sr_q[8:0], 1'b0};
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sr_q <= 10'h000;
        end else if (ce_in) begin
            sr_q <= sr_d;
        end
    end

    assign bit_out = sr_q[9];

endmodule

/* File: testbench/fsi_src_model.sv */
// Upstream symbol pair source feeding the injector
`timescale 1ns/10ps
module fsi_src_model (
    // Clock and reset
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    // Stream control
    input  wire logic               take_in,
    input  wire logic               jk_req_in,
    // Stream out
    output fsi_pkg::fsi_pair_t      pair_out,
    output logic                    jk_out,
    output fsi_pkg::fsi_pair_t      sent_out,
    output logic                    sent_jk_out
);
    logic [4:0]         seq_q;
    logic               jk_q;
    fsi_pkg::fsi_pair_t cur;

    assign cur = '{first: seq_q, second: seq_q ^ 5'h03};
    // Lines not being taken show the inverse, never a stale copy
    assign pair_out = take_in ? cur : fsi_pkg::fsi_pair_t'(~cur);
    assign jk_out   = take_in ? jk_q : ~jk_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seq_q       <= 5'h00;
            jk_q        <= 1'b0;
            sent_out    <= '0;
            sent_jk_out <= 1'b0;
        end else begin
            if (jk_req_in) begin
                jk_q <= 1'b1;
            end
            if (take_in) begin
                sent_out    <= cur;
                sent_jk_out <= jk_q;
                seq_q       <= seq_q + 5'h01;
                if (!jk_req_in) begin
                    jk_q <= 1'b0;
                end
            end
        end
    end
endmodule

/* File: testbench/testbench.sv */
// Register and stream tests of the symbol injector
`timescale 1ns/10ps
module testbench;
    logic                  sys_clk_in;
    logic                  nrst_in;
    logic                  ce;
    logic                  jk_req;
    fsi_pkg::fsi_cb_req_t  cb;
    logic [7:0]            rdata;
    fsi_pkg::fsi_pair_t    up_pair;
    logic                  up_jk;
    logic                  take;
    fsi_pkg::fsi_pair_t    tx_pair;
    logic                  tx_inj;
    logic                  tx_bit;
    fsi_pkg::fsi_pair_t    sent;
    logic                  sent_jk;
    int                    bad_count;
    int                    n_tests;
    localparam fsi_pkg::fsi_pair_t SYM = '{first: 5'h15, second: 5'h0a};

    initial sys_clk_in = 1'b0;
    always #2.5 sys_clk_in = ~sys_clk_in;

    fsi_injector dut (
        .sys_clk_in      (sys_clk_in),
        .nrst_in         (nrst_in),
        .ce_in           (ce),
        .cb_req_in       (cb),
        .cb_rdata_out    (rdata),
        .pair_in         (up_pair),
        .pair_jk_in      (up_jk),
        .pair_take_out   (take),
        .tx_pair_out     (tx_pair),
        .tx_injected_out (tx_inj),
        .tx_bit_out      (tx_bit)
    );

    fsi_src_model src (
        .clk_in      (sys_clk_in),
        .rst_n_in    (nrst_in),
        .take_in     (take),
        .jk_req_in   (jk_req),
        .pair_out    (up_pair),
        .jk_out      (up_jk),
        .sent_out    (sent),
        .sent_jk_out (sent_jk)
    );

    task automatic results;
        if (bad_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        cb <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_in);
        cb <= '0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        @(posedge sys_clk_in);
        cb <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_in);
        cb <= '0;
        #1;
        chk($sformatf("reg %h", a), {2'b00, exp}, {2'b00, rdata});
    endtask

    task automatic set_mode(input logic [1:0] m);
        wr(fsi_pkg::TSR_OFS, {3'b100, m, 3'b000});
    endtask

    // Waits for one pair slot, then checks what went out
    task automatic tick(input logic exp_inj);
        int i;
        for (i = 0; i < 40 && take !== 1'b1; i++) begin
            @(negedge sys_clk_in);
        end
        if (take !== 1'b1) begin
            $display("CHECK FAILED pair slot expected 1 seen 0");
            bad_count++;
            results();
        end else begin
            @(posedge sys_clk_in);
            #1;
            chk("injected", {9'h000, exp_inj}, {9'h000, tx_inj});
            chk("tx pair", exp_inj ? SYM : sent, tx_pair);
            @(negedge sys_clk_in);
        end
    endtask

    task automatic jk_pulse;
        @(posedge sys_clk_in);
        jk_req <= 1'b1;
        @(posedge sys_clk_in);
        jk_req <= 1'b0;
    endtask

    // Alternating pattern makes every bit a separate run on the wire
    task automatic serial_chk;
        int i;
        int runs;
        logic last;
        runs = 0;
        last = 1'b0;
        chk("first bit", 10'h001, {9'h000, tx_bit});
        for (i = 0; i < 16; i++) begin
            if (tx_bit !== last) begin
                runs++;
            end
            last = tx_bit;
            @(posedge sys_clk_in);
            #1;
        end
        chk("bit runs", 10'h00a, 10'(runs));
    endtask

    initial begin
        bad_count = 0;
        n_tests   = 0;
        nrst_in   = 1'b0;
        jk_req    = 1'b0;
        ce        = 1'b1;
        cb        = '0;
        repeat (2) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        rd(fsi_pkg::TSR_OFS, 8'h80);
        rd(fsi_pkg::THR_OFS, 8'h00);
        rd(fsi_pkg::SYMA_OFS, 8'h00);
        rd(fsi_pkg::SYMB_OFS, 8'h00);
        rd(fsi_pkg::CNT_OFS, 8'h00);
        wr(fsi_pkg::SYMA_OFS, 8'hf5);
        wr(fsi_pkg::SYMB_OFS, 8'hea);
        rd(fsi_pkg::SYMA_OFS, 8'h15);
        rd(fsi_pkg::SYMB_OFS, 8'h0a);
        rd(5'h10, 8'h00);
        wr(fsi_pkg::CNT_OFS, 8'h55);
        wr(fsi_pkg::THR_OFS, 8'h03);
        rd(fsi_pkg::CNT_OFS, 8'h03);
        tick(1'b0);
        tick(1'b0);
        rd(fsi_pkg::CNT_OFS, 8'h03);
        set_mode(2'b11);
        tick(1'b1);
        serial_chk();
        tick(1'b1);
        rd(fsi_pkg::CNT_OFS, 8'h03);
        set_mode(2'b00);
        wr(fsi_pkg::THR_OFS, 8'h02);
        set_mode(2'b10);
        tick(1'b0);
        rd(fsi_pkg::CNT_OFS, 8'h01);
        tick(1'b0);
        tick(1'b1);
        rd(fsi_pkg::CNT_OFS, 8'h02);
        tick(1'b0);
        tick(1'b0);
        tick(1'b1);
        // Enable low for longer than a pair slot: a running counter would step
        @(posedge sys_clk_in);
        ce <= 1'b0;
        repeat (20) @(posedge sys_clk_in);
        ce <= 1'b1;
        rd(fsi_pkg::CNT_OFS, 8'h02);
        wr(fsi_pkg::THR_OFS, 8'h00);
        tick(1'b1);
        tick(1'b1);
        set_mode(2'b00);
        set_mode(2'b01);
        jk_pulse();
        tick(1'b1);
        rd(fsi_pkg::TSR_OFS, 8'h80);
        tick(1'b0);
        wr(fsi_pkg::THR_OFS, 8'h03);
        set_mode(2'b01);
        jk_pulse();
        tick(1'b0);
        chk("jk sent", 10'h001, {9'h000, sent_jk});
        tick(1'b0);
        tick(1'b0);
        tick(1'b1);
        rd(fsi_pkg::TSR_OFS, 8'h80);
        tick(1'b0);
        results();
    end
endmodule
